// File: pkg/bpp_map.vh
/*
  register offsets, field positions and reset values of the parallel port.
  assumes inclusion by bare name from the design file.
*/
`ifndef BPP_MAP_VH
`define BPP_MAP_VH
`define BPP_OFS_IDENT 4'h0
`define BPP_OFS_INTDMA 4'h1
`define BPP_OFS_PSTAT 4'ha
`define BPP_OFS_CSTAT 4'hb
`define BPP_OFS_HLINE 4'hc
`define BPP_OFS_IOCTL 4'hd
`define BPP_OFS_FIFO 4'he
`define BPP_IDENT_VAL 8'h5a
`define BPP_HLINE_RST 3'h5
`define BPP_CNT_LAST 8'h01
`define BPP_IOCTL_RST 2'h0
`define BPP_BIT_INIT 2
`define BPP_BIT_ONLINE 1
`define BPP_BIT_DIR 0
`define BPP_BIT_MOD 1
`define BPP_BIT_INPUT 0
`endif

// File: rtl/bpp_port.v
/*
  host parallel port: register file, data fifo and strobe handshake.
  assumes synchronous cable inputs, one 40 mhz clock and a simple
  8-bit register port with one-cycle read and write strobes.
*/
// What this block does
// - host_online pin is driven by the port
// - peripheral_init asserted tells peripheral to reset; bidirectional ones obey
// - identity register at offset zero always returns fixed byte
// - nonzero write to offset zero resets the interface
// - bit 7 shows interrupt enable, bit 6 service request
// - bits 5-4 show fixed hardware interrupt level code
// - bits 1 and 0 show dma enables; bits 3-2 read zero
// - interrupt and both dma enables are fixed by parameters, zero by default; reset does not change them
// - peripheral status live-reflects fault and online lines
// - comm status shows fifo full, empty, busy, ack low
// - after reset fifo empty and strobe released
// - host line control bits drive init, online and direction pins
// - reset drives init asserted, online high, direction high
// - modifier bit selects ack handshake on output and fifo depth on input
// - direction bit selects input when set; reset clears both bits
// - fifo write in input mode or when full is discarded
// - sender marks valid data with active-low strobe
// - receiver holds busy high while it cannot accept
// - direction_out high means output, low input
`timescale 1ns/10ps
`include "bpp_map.vh"
module bpp_port #(
  parameter DEPTH_LOG2 = 4,
  parameter STROBE_CYCLES = 4,
  parameter [1:0] IRQ_LEVEL = 2'h0,
  parameter INT_ENABLE = 1'b0,
  parameter [1:0] DMA_ENABLE = 2'h0
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // register port
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // cable inputs
  input wire general_fault_n,
  input wire peripheral_online,
  input wire paper_fault,
  input wire busy,
  input wire peripheral_ack_pulse_n,
  input wire service_request,
  // cable outputs
  output wire peripheral_init_n,
  output wire host_online_n,
  output wire direction_out,
  output reg data_qualify_strobe_n,
  // two-way data lines, oe low while driving
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output wire data_oe_n,
  // receiving side busy driven toward peripheral in input mode
  output wire host_busy
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam PW = DEPTH_LOG2 + 1;
  localparam S_IDLE = 2'h0;
  localparam S_STROBE = 2'h1;
  localparam S_WAIT = 2'h2;

  // true when a strobe hits the given register offset
  function reg_hit;
    input strobe;
    input [3:0] addr;
    input [3:0] offset;
    begin
      reg_hit = strobe && (addr == offset);
    end
  endfunction

  // fifo storage and pointers
  reg [7:0] mem [0:DEPTH-1];
  reg [PW-1:0] wptr_reg;
  reg [PW-1:0] wptr_next;
  reg [PW-1:0] rptr_reg;
  reg [PW-1:0] rptr_next;
  // host line and io control registers
  reg [2:0] hline_reg;
  reg [2:0] hline_next;
  reg [1:0] ioctl_reg;
  reg [1:0] ioctl_next;
  // output handshake state
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg ack_seen_reg;
  reg ack_seen_next;
  reg strobe_next;
  reg [7:0] data_out_next;
  // ack line history, idle high so no false edge after reset
  reg ack_d_reg;

  // register strobe decoding
  wire soft_rst;
  wire any_rst;
  wire hline_wr;
  wire ioctl_wr;
  wire fifo_wr;
  wire fifo_rd;
  assign soft_rst = reg_hit(reg_wr, reg_addr, `BPP_OFS_IDENT) &&
    (reg_wdata != 8'h00);
  assign any_rst = rst | soft_rst;
  assign hline_wr = reg_hit(reg_wr, reg_addr, `BPP_OFS_HLINE);
  assign ioctl_wr = reg_hit(reg_wr, reg_addr, `BPP_OFS_IOCTL);
  assign fifo_wr = reg_hit(reg_wr, reg_addr, `BPP_OFS_FIFO);
  assign fifo_rd = reg_hit(reg_rd, reg_addr, `BPP_OFS_FIFO);

  // fifo fill level
  wire input_mode;
  wire modifier;
  wire [PW-1:0] count;
  wire empty;
  wire full;
  assign input_mode = ioctl_reg[`BPP_BIT_INPUT];
  assign modifier = ioctl_reg[`BPP_BIT_MOD];
  assign count = wptr_reg - rptr_reg;
  assign empty = (count == {PW{1'b0}});
  // one location only when the modifier is set on input
  assign full = (input_mode && modifier) ? !empty :
    count[DEPTH_LOG2];

  // push and pop sources
  wire ack_fall;
  wire cpu_push;
  wire in_push;
  wire push;
  wire [7:0] push_data;
  wire cpu_pop;
  wire out_pop;
  wire pop;
  assign ack_fall = ack_d_reg && !peripheral_ack_pulse_n;
  // writes in input mode or into a full fifo are dropped
  assign cpu_push = fifo_wr && !input_mode && !full;
  // inbound byte is taken on the falling edge of the ack line
  assign in_push = input_mode && !full && ack_fall;
  assign push = cpu_push | in_push;
  assign push_data = input_mode ? data_in : reg_wdata;
  // junk reads do not move the read pointer
  assign cpu_pop = fifo_rd && input_mode && !empty;
  assign out_pop = !input_mode && (state_reg == S_IDLE) && !empty &&
    !busy;
  assign pop = cpu_pop | out_pop;

  // cable outputs
  assign peripheral_init_n = ~hline_reg[`BPP_BIT_INIT];
  assign host_online_n = ~hline_reg[`BPP_BIT_ONLINE];
  assign direction_out = hline_reg[`BPP_BIT_DIR];
  // data lines driven only while the direction is output
  assign data_oe_n = input_mode;
  assign host_busy = input_mode && full;

  // pointer next values
  always @* begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    if (push) begin
      wptr_next = wptr_reg + {{(PW-1){1'b0}}, 1'b1};
    end
    if (pop) begin
      rptr_next = rptr_reg + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // control register next values
  always @* begin
    hline_next = hline_reg;
    ioctl_next = ioctl_reg;
    if (hline_wr) begin
      hline_next = reg_wdata[2:0];
    end
    if (ioctl_wr) begin
      ioctl_next = reg_wdata[1:0];
    end
  end

  // output strobe handshake
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ack_seen_next = ack_seen_reg;
    strobe_next = data_qualify_strobe_n;
    data_out_next = data_out;
    case (state_reg)
      S_IDLE: begin
        if (out_pop) begin
          data_out_next = mem[rptr_reg[DEPTH_LOG2-1:0]];
          strobe_next = 1'b0;
          cnt_next = STROBE_CYCLES[7:0];
          ack_seen_next = 1'b0;
          state_next = S_STROBE;
        end
      end
      S_STROBE: begin
        if (cnt_reg == `BPP_CNT_LAST) begin
          strobe_next = 1'b1;
          state_next = S_WAIT;
        end else begin
          cnt_next = cnt_reg - `BPP_CNT_LAST;
        end
        if (ack_fall) begin
          ack_seen_next = 1'b1;
        end
      end
      S_WAIT: begin
        if (ack_fall) begin
          ack_seen_next = 1'b1;
        end
        // cleared modifier needs ack as well as busy low
        if (!busy && (modifier || ack_seen_reg || ack_fall)) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // fifo pointers
  always @(posedge sys_clk) begin
    if (any_rst) begin
      wptr_reg <= {PW{1'b0}};
      rptr_reg <= {PW{1'b0}};
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
  end

  // control registers
  always @(posedge sys_clk) begin
    if (any_rst) begin
      hline_reg <= `BPP_HLINE_RST;
      ioctl_reg <= `BPP_IOCTL_RST;
    end else begin
      hline_reg <= hline_next;
      ioctl_reg <= ioctl_next;
    end
  end

  // handshake registers and data lines
  always @(posedge sys_clk) begin
    if (any_rst) begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      ack_seen_reg <= 1'b0;
      ack_d_reg <= 1'b1;
      data_qualify_strobe_n <= 1'b1;
      data_out <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ack_seen_reg <= ack_seen_next;
      ack_d_reg <= peripheral_ack_pulse_n;
      data_qualify_strobe_n <= strobe_next;
      data_out <= data_out_next;
    end
  end

  // fifo storage has no reset; stale words are never popped
  always @(posedge sys_clk) begin
    if (push && !any_rst) begin
      mem[wptr_reg[DEPTH_LOG2-1:0]] <= push_data;
    end
  end

  // read words
  wire [7:0] intdma_word;
  wire [7:0] pstat_word;
  wire [7:0] cstat_word;
  wire [7:0] hline_word;
  wire [7:0] ioctl_word;
  wire [7:0] fifo_word;
  // enable, request, level, two zero bits, dma enables
  assign intdma_word = {INT_ENABLE[0], service_request, IRQ_LEVEL,
    2'b00, DMA_ENABLE};
  assign pstat_word = {5'h00, !general_fault_n, peripheral_online,
    paper_fault};
  assign cstat_word = {3'h0, full, empty, !data_qualify_strobe_n, busy,
    !peripheral_ack_pulse_n};
  assign hline_word = {5'h00, hline_reg};
  assign ioctl_word = {6'h00, ioctl_reg};
  assign fifo_word = mem[rptr_reg[DEPTH_LOG2-1:0]];

  // read data select
  always @* begin
    if (reg_addr == `BPP_OFS_IDENT) begin
      reg_rdata = `BPP_IDENT_VAL;
    end else if (reg_addr == `BPP_OFS_INTDMA) begin
      reg_rdata = intdma_word;
    end else if (reg_addr == `BPP_OFS_PSTAT) begin
      reg_rdata = pstat_word;
    end else if (reg_addr == `BPP_OFS_CSTAT) begin
      reg_rdata = cstat_word;
    end else if (reg_addr == `BPP_OFS_HLINE) begin
      reg_rdata = hline_word;
    end else if (reg_addr == `BPP_OFS_IOCTL) begin
      reg_rdata = ioctl_word;
    end else if (reg_addr == `BPP_OFS_FIFO) begin
      reg_rdata = fifo_word;
    end else begin
      reg_rdata = 8'h00;
    end
  end
endmodule // bpp_port

// File: verification/bpp_port_assertions.sv
/* assertions on the port's pins and register reads.
   assumes binding onto bpp_port with default strobe length. */
`timescale 1ns/10ps
module bpp_port_assertions (
  // clock, reset and register port
  input wire sys_clk, rst, reg_wr,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata, reg_rdata,
  // cable lines
  input wire general_fault_n, peripheral_online, paper_fault,
  input wire peripheral_init_n, host_online_n, direction_out,
  input wire data_qualify_strobe_n, data_oe_n, host_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_stb; !data_qualify_strobe_n[*4] ##1 data_qualify_strobe_n;
  endsequence
  a_ident_fixed: assert property (reg_addr == 0 |->
    reg_rdata == 8'h5a) else $error("identity byte");
  a_pstat_live: assert property (reg_addr == 4'ha |-> reg_rdata ==
    {5'h0, !general_fault_n, peripheral_online, paper_fault})
    else $error("pstat");
  a_cstat_bits: assert property (reg_addr == 4'hb |->
    reg_rdata[7:5] == 0 && reg_rdata[2] == !data_qualify_strobe_n)
    else $error("cstat");
  a_line_write: assert property (reg_wr && reg_addr == 4'hc |=>
    direction_out == $past(reg_wdata[0])
    && host_online_n != $past(reg_wdata[1])
    && peripheral_init_n != $past(reg_wdata[2])) else $error("line control");
  a_soft_reset: assert property (reg_wr && reg_addr == 0 &&
    reg_wdata != 0 |=> !peripheral_init_n && host_online_n && direction_out)
    else $error("soft reset");
  a_reset_pins: assert property ($fell(rst) |-> !peripheral_init_n &&
    host_online_n && direction_out) else $error("reset pins");
  a_strobe_len: assert property ($fell(data_qualify_strobe_n) |->
    s_stb) else $error("strobe length");
  a_strobe_drive: assert property (!data_qualify_strobe_n |->
    !data_oe_n) else $error("strobe without drive");
  a_busy_full: assert property (data_oe_n && reg_addr == 4'hb |->
    reg_rdata[4] == host_busy) else $error("busy not full");
endmodule // bpp_port_assertions
bind bpp_port bpp_port_assertions u_chk (.sys_clk, .rst, .reg_wr, .reg_addr,
  .reg_wdata, .reg_rdata, .general_fault_n, .peripheral_online, .paper_fault,
  .peripheral_init_n, .host_online_n, .direction_out, .data_qualify_strobe_n,
  .data_oe_n, .host_busy);

// File: verification/bpp_peer.sv
/* peripheral model: takes strobed bytes, sends bytes on request.
   assumes the port holds its strobe low for a few cycles. */
`timescale 1ns/10ps
module bpp_peer (
  input wire sys_clk, data_qualify_strobe_n, send,
  input wire [7:0] data_out, send_byte,
  output reg busy = 0, peripheral_ack_pulse_n = 1,
  output reg [7:0] data_in = 0, got_byte = 0
);
  reg [2:0] cnt_reg = 0;
  always @(posedge sys_clk) begin
    if (cnt_reg != 0) begin
      cnt_reg <= cnt_reg - 3'h1;
      peripheral_ack_pulse_n <= cnt_reg[2:1] != 2'h1;
      if (cnt_reg == 3'h3) busy <= 0;
      if (cnt_reg == 3'h1) data_in <= ~data_in;
    end else if (!data_qualify_strobe_n) begin
      got_byte <= data_out;
      busy <= 1;
      cnt_reg <= 3'h6;
    end else if (send) begin
      data_in <= send_byte;
      cnt_reg <= 3'h6;
    end
  end
endmodule // bpp_peer

// File: verification/bidir_parallel_host_port_test.sv
/* testbench: register reads and writes, both data directions.
   assumes the peripheral model on the cable side. */
`timescale 1ns/10ps
module bidir_parallel_host_port_test;
  reg sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, send = 0;
  reg general_fault_n = 0, peripheral_online = 1, paper_fault = 0;
  reg srq = 1;
  reg [3:0] reg_addr = 0;
  reg [7:0] reg_wdata = 0, send_byte = 8'h96;
  wire [7:0] reg_rdata, data_in, data_out, got_byte;
  wire busy, ack_n, stb_n, init_n, online_n, dir, oe_n, hbusy;
  integer errors = 0, comparisons = 0, cyc = 0, i;
  always #12.5 sys_clk = ~sys_clk;
  bpp_port #(.IRQ_LEVEL(2'h2)) dut (.sys_clk, .rst, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .general_fault_n, .peripheral_online,
    .paper_fault, .busy, .peripheral_ack_pulse_n(ack_n), .service_request(srq),
    .peripheral_init_n(init_n), .host_online_n(online_n), .direction_out(dir),
    .data_qualify_strobe_n(stb_n), .data_in, .data_out, .data_oe_n(oe_n),
    .host_busy(hbusy));
  bpp_peer peer (.sys_clk, .data_qualify_strobe_n(stb_n), .send, .data_out,
    .send_byte, .busy, .peripheral_ack_pulse_n(ack_n), .data_in, .got_byte);
  task chk(input [7:0] g, e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    #1 chk(reg_rdata, e);
    @(posedge sys_clk);
    reg_rd <= 0;
  endtask
  task pins(input [7:0] e);
    #1 chk({3'h0, hbusy, oe_n, init_n, online_n, dir}, e);
  endtask
  task pulse_send(input [7:0] b);
    @(posedge sys_clk) {send, send_byte} <= {1'b1, b};
    @(posedge sys_clk) send <= 0;
    repeat (10) @(posedge sys_clk);
  endtask
  task wt(input [7:0] e);
    for (i = 0; i < 40 && got_byte !== e; i = i + 1) @(posedge sys_clk);
    chk(got_byte, e);
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 0;
    pins(8'h03);
    rd(4'hd, 8'h00);
    rd(4'hc, 8'h05);
    rd(4'h1, 8'h60);
    rd(4'hb, 8'h08);
    rd(4'h0, 8'h5a);
    rd(4'ha, 8'h06);
    @(posedge sys_clk)
      {general_fault_n, peripheral_online, paper_fault, srq} <= 4'b1010;
    rd(4'ha, 8'h01);
    rd(4'h1, 8'h20);
    wr(4'hc, 8'hff);
    pins(8'h01);
    wr(4'h0, 8'h00);
    rd(4'hc, 8'h07);
    wr(4'h0, 8'h80);
    rd(4'hc, 8'h05);
    pins(8'h03);
    wr(4'hc, 8'h01);
    wr(4'he, 8'ha5);
    wr(4'he, 8'h3c);
    wt(8'ha5);
    wt(8'h3c);
    repeat (8) @(posedge sys_clk);
    wr(4'hc, 8'h00);
    wr(4'hd, 8'h01);
    pins(8'h0e);
    pulse_send(8'h96);
    rd(4'he, 8'h96);
    wr(4'he, 8'h11);
    rd(4'hb, 8'h08);
    wr(4'hd, 8'h03);
    pulse_send(8'h96);
    rd(4'hb, 8'h10);
    pins(8'h1e);
    pulse_send(8'h5c);
    rd(4'he, 8'h96);
    rd(4'hb, 8'h08);
    finish_test;
  end
endmodule // bidir_parallel_host_port_test
